// [comp_ch_if.sv]
// Purpose: Signals between the control block and one comparator channel
// Assumes: One clock domain
// Notes: raw_sync is already synchronised
`timescale 1ns/1ns
interface comp_ch_if;
   logic enable;
   logic polarity;
   logic raw_sync;
   logic read_strobe;
   logic out_status;
   logic mismatch;
   logic mismatch_rise;
   modport chan (
      input enable, polarity, raw_sync, read_strobe,
      output out_status, mismatch, mismatch_rise
   );
   modport ctrl (
      output enable, polarity, raw_sync, read_strobe,
      input out_status, mismatch, mismatch_rise
   );
endinterface : comp_ch_if

// [comp_channel.sv]
// Purpose: Output status and mismatch latches of one comparator
// Assumes: Every pclk edge is a first clock phase
// Notes: Read latch is loaded only by control register accesses
`timescale 1ns/1ns
module comp_channel (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Channel
   comp_ch_if.chan ch
);
   logic read_q;
   logic sample_q;
   logic mismatch_q;

   // Disabled comparator shows the polarity level
   assign ch.out_status = ch.enable ? (ch.raw_sync ^ ch.polarity) :
                          ch.polarity;
   assign ch.mismatch = read_q ^ sample_q;
   assign ch.mismatch_rise = ch.mismatch & ~mismatch_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_q <= 1'b0;
      end else if (ch.read_strobe) begin
         read_q <= ch.out_status;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_q <= 1'b0;
         mismatch_q <= 1'b0;
      end else begin
         sample_q <= ch.out_status;
         mismatch_q <= ch.mismatch;
      end
   end

   property p_disabled_level;
      @(posedge pclk) disable iff (!presetn)
      !ch.enable |-> ##1 (!ch.enable |-> ch.out_status == ch.polarity);
   endproperty
   a_disabled_level: assert property (p_disabled_level)
      else $error("disabled status wrong");

   property p_read_clears;
      @(posedge pclk) disable iff (!presetn)
      ch.read_strobe |=> !ch.mismatch;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read left mismatch");
endmodule : comp_channel

// [comp_ctrl_pkg.sv]
// Purpose: Shared constants for the dual comparator control block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Only the low byte of each register is implemented
package comp_ctrl_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL1 = 8'h00;
   localparam logic [7:0] OFF_CTRL2 = 8'h04;
   localparam logic [7:0] OFF_AUX = 8'h08;
   localparam logic [7:0] OFF_FLAG = 8'h0C;
   localparam logic [7:0] OFF_IRQEN = 8'h10;
   localparam logic [7:0] OFF_SLEEP = 8'h14;
   // Control register fields
   localparam int CTL_ENABLE = 7;
   localparam int CTL_STATUS = 6;
   localparam int CTL_PIN_OE = 5;
   localparam int CTL_POL = 4;
   localparam int CTL_SPEED = 3;
   localparam int CTL_REF = 2;
   localparam int CTL_NEG_HI = 1;
   localparam int CTL_NEG_LO = 0;
   localparam logic [7:0] CTL_WMASK = 8'hBF;
   // Auxiliary register fields
   localparam int AUX_MIRROR1 = 7;
   localparam int AUX_MIRROR2 = 6;
   localparam logic [5:0] AUX_WMASK = 6'h3F;
   // Interrupt enable register fields
   localparam int IEN_C1 = 0;
   localparam int IEN_C2 = 1;
   localparam int IEN_PERIPH = 2;
   localparam int IEN_GLOBAL = 3;
   // Sleep register field
   localparam int SLP_ENTER = 0;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [5:0] AUX_RESET = 6'h00;
   localparam logic [1:0] FLAG_RESET = 2'h0;
   localparam logic [3:0] IRQEN_RESET = 4'h0;
endpackage : comp_ctrl_pkg

// [dual_comparator_control.sv]
// Purpose: APB control and status logic for two analog comparators
// Assumes: Each pclk edge stands for one first clock phase
// Notes: Offsets past the second control register are local choices
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module dual_comparator_control (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog cores
   input wire logic [1:0] comp_raw,
   output logic [1:0] comp_enable,
   output logic [1:0] comp_speed_select,
   output logic [1:0] comp_ref_route,
   output logic [3:0] comp_neg_input_select,
   output logic [1:0] ref_source_select,
   output logic [1:0] hysteresis_enable,
   output logic [1:0] timer_sync_enable,
   // Shared output pin
   input wire logic port_direction_bit,
   output logic shared_comp_out_pin,
   output logic shared_comp_out_pin_oe,
   // Core interface
   output logic sleeping,
   output logic wake_pulse,
   output logic irq_request
);
   logic [7:0] ctrl_q [2];
   logic [5:0] aux_q;
   logic [1:0] flag_q;
   logic [3:0] irqen_q;
   logic sleep_q;
   logic wake_q;
   logic [1:0] raw_meta_q;
   logic [1:0] raw_sync_q;
   logic pin_q;
   logic pin_oe_q;
   logic [31:0] prdata_q;
   logic err_q;
   logic setup;
   logic wr_acc;
   logic hit;
   logic [1:0] status;
   logic [1:0] rise;
   logic [1:0] pending;
   logic [1:0] pin_drive;

   comp_ch_if ch1 ();
   comp_ch_if ch2 ();

   comp_channel u_ch1 (
      .pclk(pclk),
      .presetn(presetn),
      .ch(ch1.chan)
   );
   comp_channel u_ch2 (
      .pclk(pclk),
      .presetn(presetn),
      .ch(ch2.chan)
   );

   function automatic logic [7:0] ctrl_read(input logic [7:0] c, input logic s);
      logic [7:0] r;
      r = c & comp_ctrl_pkg::CTL_WMASK;
      r[comp_ctrl_pkg::CTL_STATUS] = s;
      return r;
   endfunction : ctrl_read

   function automatic logic addr_mapped(input logic [7:0] a);
      return a == comp_ctrl_pkg::OFF_CTRL1 || a == comp_ctrl_pkg::OFF_CTRL2 ||
             a == comp_ctrl_pkg::OFF_AUX || a == comp_ctrl_pkg::OFF_FLAG ||
             a == comp_ctrl_pkg::OFF_IRQEN || a == comp_ctrl_pkg::OFF_SLEEP;
   endfunction : addr_mapped

   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pwrite & hit;
   assign hit = addr_mapped(paddr);
   assign pready = 1'b1;
   assign pslverr = psel & penable & err_q;
   assign prdata = prdata_q;

   // Comparator outputs arrive asynchronously
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_meta_q <= 2'h0;
         raw_sync_q <= 2'h0;
      end else begin
         raw_meta_q <= comp_raw;
         raw_sync_q <= raw_meta_q;
      end
   end

   assign ch1.enable = ctrl_q[0][comp_ctrl_pkg::CTL_ENABLE];
   assign ch1.polarity = ctrl_q[0][comp_ctrl_pkg::CTL_POL];
   assign ch1.raw_sync = raw_sync_q[0];
   assign ch2.enable = ctrl_q[1][comp_ctrl_pkg::CTL_ENABLE];
   assign ch2.polarity = ctrl_q[1][comp_ctrl_pkg::CTL_POL];
   assign ch2.raw_sync = raw_sync_q[1];
   // Any control register access, read or write, reads at setup
   assign ch1.read_strobe = setup & (paddr == comp_ctrl_pkg::OFF_CTRL1);
   assign ch2.read_strobe = setup & (paddr == comp_ctrl_pkg::OFF_CTRL2);
   assign status = {ch2.out_status, ch1.out_status};
   assign rise = {ch2.mismatch_rise, ch1.mismatch_rise};

   // Enables act regardless of sleep
   assign comp_enable = {ctrl_q[1][comp_ctrl_pkg::CTL_ENABLE],
                         ctrl_q[0][comp_ctrl_pkg::CTL_ENABLE]};
   assign comp_speed_select = {ctrl_q[1][comp_ctrl_pkg::CTL_SPEED],
                               ctrl_q[0][comp_ctrl_pkg::CTL_SPEED]};
   assign comp_ref_route = {ctrl_q[1][comp_ctrl_pkg::CTL_REF],
                            ctrl_q[0][comp_ctrl_pkg::CTL_REF]};
   assign comp_neg_input_select = {ctrl_q[1][comp_ctrl_pkg::CTL_NEG_HI:comp_ctrl_pkg::CTL_NEG_LO],
                                   ctrl_q[0][comp_ctrl_pkg::CTL_NEG_HI:
                                             comp_ctrl_pkg::CTL_NEG_LO]};
   assign ref_source_select = aux_q[5:4];
   assign hysteresis_enable = aux_q[3:2];
   assign timer_sync_enable = aux_q[1:0];

   // Control registers: new fields land at the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q[0] <= comp_ctrl_pkg::CTRL_RESET;
         ctrl_q[1] <= comp_ctrl_pkg::CTRL_RESET;
         aux_q <= comp_ctrl_pkg::AUX_RESET;
      end else if (wr_acc) begin
         if (paddr == comp_ctrl_pkg::OFF_CTRL1) begin
            ctrl_q[0] <= pwdata[7:0] & comp_ctrl_pkg::CTL_WMASK;
         end else if (paddr == comp_ctrl_pkg::OFF_CTRL2) begin
            ctrl_q[1] <= pwdata[7:0] & comp_ctrl_pkg::CTL_WMASK;
         end else if (paddr == comp_ctrl_pkg::OFF_AUX) begin
            aux_q <= pwdata[5:0] & comp_ctrl_pkg::AUX_WMASK;
         end
      end
   end

   // Flags: hardware set wins over a software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= comp_ctrl_pkg::FLAG_RESET;
      end else if (wr_acc && paddr == comp_ctrl_pkg::OFF_FLAG) begin
         flag_q <= pwdata[1:0] | rise;
      end else begin
         flag_q <= flag_q | rise;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irqen_q <= comp_ctrl_pkg::IRQEN_RESET;
      end else if (wr_acc && paddr == comp_ctrl_pkg::OFF_IRQEN) begin
         irqen_q <= pwdata[3:0];
      end
   end

   assign pending = flag_q & {irqen_q[comp_ctrl_pkg::IEN_C2], irqen_q[comp_ctrl_pkg::IEN_C1]};

   // Sleep and wake-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         wake_q <= 1'b0;
         if (sleep_q && (|pending) && irqen_q[comp_ctrl_pkg::IEN_PERIPH]) begin
            sleep_q <= 1'b0;
            wake_q <= 1'b1;
         end else if (wr_acc && paddr == comp_ctrl_pkg::OFF_SLEEP) begin
            sleep_q <= pwdata[comp_ctrl_pkg::SLP_ENTER];
         end
      end
   end

   assign sleeping = sleep_q;
   assign wake_pulse = wake_q;
   // Vectoring waits one cycle after wake for the following instruction
   assign irq_request = (|pending) & irqen_q[comp_ctrl_pkg::IEN_PERIPH] &
                        irqen_q[comp_ctrl_pkg::IEN_GLOBAL] & ~sleep_q & ~wake_q;

   // Shared pin: second comparator has priority
   assign pin_drive = {ctrl_q[1][comp_ctrl_pkg::CTL_PIN_OE], ctrl_q[0][comp_ctrl_pkg::CTL_PIN_OE]};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end else if (pin_drive[1]) begin
         pin_q <= status[1];
         pin_oe_q <= comp_enable[1] & ~port_direction_bit;
      end else begin
         pin_q <= status[0];
         pin_oe_q <= pin_drive[0] & comp_enable[0] & ~port_direction_bit;
      end
   end
   assign shared_comp_out_pin = pin_q;
   assign shared_comp_out_pin_oe = pin_oe_q;

   // Read data captured at setup; mirrors do not touch latches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end else if (setup) begin
         err_q <= ~hit;
         prdata_q <= 32'h0000_0000;
         if (paddr == comp_ctrl_pkg::OFF_CTRL1) begin
            prdata_q[7:0] <= ctrl_read(ctrl_q[0], status[0]);
         end else if (paddr == comp_ctrl_pkg::OFF_CTRL2) begin
            prdata_q[7:0] <= ctrl_read(ctrl_q[1], status[1]);
         end else if (paddr == comp_ctrl_pkg::OFF_AUX) begin
            prdata_q[7:0] <= {status[0], status[1], aux_q};
         end else if (paddr == comp_ctrl_pkg::OFF_FLAG) begin
            prdata_q[1:0] <= flag_q;
         end else if (paddr == comp_ctrl_pkg::OFF_IRQEN) begin
            prdata_q[3:0] <= irqen_q;
         end else if (paddr == comp_ctrl_pkg::OFF_SLEEP) begin
            prdata_q[0] <= sleep_q;
         end
      end
   end

   property p_flag_on_rise;
      @(posedge pclk) disable iff (!presetn)
      ch1.mismatch_rise |=> flag_q[0];
   endproperty
   a_flag_on_rise: assert property (p_flag_on_rise) else $error("flag not set");

   property p_write_clears;
      @(posedge pclk) disable iff (!presetn)
      setup && pwrite && paddr == comp_ctrl_pkg::OFF_CTRL2 |=> !ch2.mismatch;
   endproperty
   a_write_clears: assert property (p_write_clears) else $error("write kept mismatch");

   property p_enable_write;
      @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == comp_ctrl_pkg::OFF_CTRL1 |=> comp_enable[0] == $past(pwdata[7]);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable not applied");

   property p_status_ro;
      @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == comp_ctrl_pkg::OFF_CTRL1 |=> prdata[6] == $past(status[0]);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status bit wrong");

   property p_pin_priority;
      @(posedge pclk) disable iff (!presetn)
      pin_drive == 2'h3 |=> shared_comp_out_pin == $past(status[1]);
   endproperty
   a_pin_priority: assert property (p_pin_priority) else $error("pin priority wrong");

   property p_pin_gate;
      @(posedge pclk) disable iff (!presetn)
      port_direction_bit || comp_enable == 2'h0 |=> !shared_comp_out_pin_oe;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("pin driven wrongly");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
      sleep_q && |pending && irqen_q[comp_ctrl_pkg::IEN_PERIPH] |=> wake_pulse && !sleeping;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake-up");

   property p_no_vector_on_wake;
      @(posedge pclk) disable iff (!presetn)
      $rose(wake_pulse) |-> !irq_request;
   endproperty
   a_no_vector_on_wake: assert property (p_no_vector_on_wake)
      else $error("vectored early");

   property p_flag2_on_rise;
      @(posedge pclk) disable iff (!presetn)
      ch2.mismatch_rise |=> flag_q[1];
   endproperty
   a_flag2_on_rise: assert property (p_flag2_on_rise)
      else $error("second flag not set");

   // Flag moves only on a mismatch rise or a flag write
   property p_flag_hold;
      @(posedge pclk) disable iff (!presetn)
      !rise[0] && !(wr_acc && paddr == comp_ctrl_pkg::OFF_FLAG)
         |=> flag_q[0] == $past(flag_q[0]);
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag changed without cause");

   property p_fields_c2;
      @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == comp_ctrl_pkg::OFF_CTRL2 |=>
         {comp_speed_select[1], comp_ref_route[1], comp_neg_input_select[3:2]} ==
         $past(pwdata[3:0]);
   endproperty
   a_fields_c2: assert property (p_fields_c2)
      else $error("fields not applied");

   property p_status_ignored;
      @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == comp_ctrl_pkg::OFF_CTRL1 |=> !ctrl_q[0][comp_ctrl_pkg::CTL_STATUS];
   endproperty
   a_status_ignored: assert property (p_status_ignored)
      else $error("status bit stored");

   property p_stay_asleep;
      @(posedge pclk) disable iff (!presetn)
      sleep_q && !irqen_q[comp_ctrl_pkg::IEN_PERIPH] &&
         !(wr_acc && paddr == comp_ctrl_pkg::OFF_SLEEP) |=> sleeping;
   endproperty
   a_stay_asleep: assert property (p_stay_asleep)
      else $error("woke without peripheral enable");

   property p_mirror;
      @(posedge pclk) disable iff (!presetn)
      setup && paddr == comp_ctrl_pkg::OFF_AUX |=>
         prdata[7] == $past(status[0]) && prdata[6] == $past(status[1]);
   endproperty
   a_mirror: assert property (p_mirror)
      else $error("mirror bits wrong");

   c_wake: cover property (@(posedge pclk) disable iff (!presetn) wake_pulse);
   c_pin_c2: cover property (@(posedge pclk) disable iff (!presetn)
      pin_drive == 2'h3 ##1 shared_comp_out_pin_oe);
   c_flag: cover property (@(posedge pclk) disable iff (!presetn) rise != 2'h0);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq_request);
   c_read_clear: cover property (@(posedge pclk) disable iff (!presetn)
      ch1.read_strobe && ch1.mismatch);
endmodule : dual_comparator_control

// [testbench.sv]
// Purpose: Self-checking bench for dual_comparator_control over APB
// Assumes: Zero-wait slave, two-flop raw synchroniser, registered pin path
// Notes: Fixed waits after raw input changes cover the synchroniser and latches
`timescale 1ns/1ns
module testbench;
   localparam logic [7:0] A_C1 = comp_ctrl_pkg::OFF_CTRL1;
   localparam logic [7:0] A_C2 = comp_ctrl_pkg::OFF_CTRL2;
   localparam logic [7:0] A_AX = comp_ctrl_pkg::OFF_AUX;
   localparam logic [7:0] A_FL = comp_ctrl_pkg::OFF_FLAG;
   localparam logic [7:0] A_IE = comp_ctrl_pkg::OFF_IRQEN;
   localparam logic [7:0] A_SL = comp_ctrl_pkg::OFF_SLEEP;
   logic pclk, presetn, psel, penable, pwrite, port_direction_bit, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, shared_comp_out_pin, shared_comp_out_pin_oe;
   logic sleeping, wake_pulse, irq_request;
   logic [1:0] comp_raw, comp_enable, comp_speed_select, comp_ref_route;
   logic [1:0] ref_source_select, hysteresis_enable, timer_sync_enable;
   logic [3:0] comp_neg_input_select;
   int errors, cmp_count, cycles;

   dual_comparator_control dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .comp_raw(comp_raw), .comp_enable(comp_enable), .comp_speed_select(comp_speed_select),
      .comp_ref_route(comp_ref_route), .comp_neg_input_select(comp_neg_input_select),
      .ref_source_select(ref_source_select), .hysteresis_enable(hysteresis_enable),
      .timer_sync_enable(timer_sync_enable), .port_direction_bit(port_direction_bit),
      .shared_comp_out_pin(shared_comp_out_pin),
      .shared_comp_out_pin_oe(shared_comp_out_pin_oe), .sleeping(sleeping),
      .wake_pulse(wake_pulse), .irq_request(irq_request)
   );

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         results();
      end
   end

   task automatic results;
      $display("errors=%0d cmp_count=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   // One APB transfer; holds the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      apb(1'b1, addr, data);
   endtask : wr

   task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0000_0000);
      chk_word(rd, exp);
   endtask : rdchk

   task automatic t_regs;
      rdchk(A_C1, 32'h0000_0000);
      rdchk(A_C2, 32'h0000_0000);
      rdchk(A_AX, 32'h0000_0000);
      rdchk(A_FL, 32'h0000_0000);
      rdchk(A_IE, 32'h0000_0000);
      chk_word(32'(comp_enable), 32'h0000_0000);
      chk_bit(shared_comp_out_pin_oe, 1'b0);
      rdchk(8'h18, 32'h0000_0000);
      chk_bit(err, 1'b1);
      $display("test regs done");
   endtask : t_regs

   task automatic t_fields;
      logic [7:0] a;
      logic [7:0] v;
      for (int ch = 0; ch < 2; ch++) begin
         a = ch ? A_C2 : A_C1;
         for (int i = 0; i < 4; i++) begin
            v = {4'h8, 2'(i), 2'(i)};
            wr(a, {24'h0000_00, v} | 32'h0000_0040);
            rdchk(a, {24'h0000_00, v});
            chk_word(32'(comp_neg_input_select[2*ch +: 2]), 32'(i));
            chk_bit(comp_speed_select[ch], v[3]);
            chk_bit(comp_ref_route[ch], v[2]);
            chk_bit(comp_enable[ch], 1'b1);
         end
         wr(a, 32'h0000_0000);
         @(posedge pclk);
         chk_bit(comp_enable[ch], 1'b0);
      end
      wr(A_AX, 32'h0000_00FF);
      rdchk(A_AX, 32'h0000_003F);
      chk_word(32'({ref_source_select, hysteresis_enable, timer_sync_enable}), 32'h0000_003F);
      wr(A_AX, 32'h0000_0000);
      $display("test fields done");
   endtask : t_fields

   task automatic t_polarity;
      logic [7:0] a;
      comp_raw <= 2'b11;
      repeat (4) @(posedge pclk);
      for (int ch = 0; ch < 2; ch++) begin
         a = ch ? A_C2 : A_C1;
         wr(a, 32'h0000_0010);
         rdchk(a, 32'h0000_0050);
         wr(a, 32'h0000_0000);
         rdchk(a, 32'h0000_0000);
         wr(a, 32'h0000_0080);
         rdchk(a, 32'h0000_00C0);
         wr(a, 32'h0000_0090);
         rdchk(a, 32'h0000_0090);
      end
      wr(A_C1, 32'h0000_0080);
      rdchk(A_AX, 32'h0000_0080);
      comp_raw <= 2'b00;
      wr(A_C1, 32'h0000_0000);
      wr(A_C2, 32'h0000_0000);
      $display("test polarity done");
   endtask : t_polarity

   task automatic pin_case(input logic [7:0] c1, input logic [7:0] c2, input logic dir,
                           input logic exp_oe, input logic exp_pin);
      wr(A_C1, {24'h0000_00, c1});
      wr(A_C2, {24'h0000_00, c2});
      port_direction_bit <= dir;
      repeat (3) @(posedge pclk);
      chk_bit(shared_comp_out_pin_oe, exp_oe);
      if (exp_oe) chk_bit(shared_comp_out_pin, exp_pin);
   endtask : pin_case

   task automatic t_pin;
      pin_case(8'hB0, 8'h80, 1'b0, 1'b1, 1'b1);
      pin_case(8'hB0, 8'hA0, 1'b0, 1'b1, 1'b0);
      pin_case(8'hB0, 8'hA0, 1'b1, 1'b0, 1'b0);
      pin_case(8'h30, 8'h00, 1'b0, 1'b0, 1'b0);
      pin_case(8'h00, 8'h20, 1'b0, 1'b0, 1'b0);
      $display("test pin done");
   endtask : t_pin

   task automatic t_preset;
      comp_raw <= 2'b01;
      repeat (4) @(posedge pclk);
      wr(A_C1, 32'h0000_0010);
      wr(A_C1, 32'h0000_0080);
      wr(A_FL, 32'h0000_0000);
      repeat (6) @(posedge pclk);
      rdchk(A_FL, 32'h0000_0000);
      rdchk(A_C1, 32'h0000_00C0);
      comp_raw <= 2'b00;
      wr(A_C1, 32'h0000_0000);
      $display("test preset done");
   endtask : t_preset

   task automatic t_flag;
      wr(A_C1, 32'h0000_0080);
      repeat (25) @(posedge pclk);
      rdchk(A_C1, 32'h0000_0080);
      wr(A_FL, 32'h0000_0000);
      rdchk(A_FL, 32'h0000_0000);
      comp_raw <= 2'b01;
      repeat (6) @(posedge pclk);
      rdchk(A_FL, 32'h0000_0001);
      rdchk(A_AX, 32'h0000_0080);
      wr(A_FL, 32'h0000_0000);
      comp_raw <= 2'b00;
      repeat (6) @(posedge pclk);
      rdchk(A_FL, 32'h0000_0000);
      comp_raw <= 2'b01;
      repeat (6) @(posedge pclk);
      rdchk(A_FL, 32'h0000_0001);
      wr(A_FL, 32'h0000_0000);
      repeat (4) @(posedge pclk);
      rdchk(A_FL, 32'h0000_0000);
      wr(A_C1, 32'h0000_0080);
      comp_raw <= 2'b00;
      repeat (6) @(posedge pclk);
      rdchk(A_FL, 32'h0000_0001);
      wr(A_FL, 32'h0000_0002);
      rdchk(A_FL, 32'h0000_0002);
      wr(A_FL, 32'h0000_0000);
      rdchk(A_C1, 32'h0000_0080);
      $display("test flag done");
   endtask : t_flag

   task automatic t_sleep;
      int n;
      wr(A_IE, 32'h0000_0001);
      wr(A_SL, 32'h0000_0001);
      comp_raw <= 2'b01;
      repeat (8) @(posedge pclk);
      chk_bit(sleeping, 1'b1);
      chk_bit(comp_enable[0], 1'b1);
      rdchk(A_FL, 32'h0000_0001);
      rdchk(A_SL, 32'h0000_0001);
      wr(A_IE, 32'h0000_000D);
      for (n = 0; n < 20 && wake_pulse !== 1'b1; n++) begin
         @(posedge pclk);
         #1;
      end
      chk_bit(wake_pulse, 1'b1);
      chk_bit(irq_request, 1'b0);
      @(posedge pclk);
      #1;
      chk_bit(sleeping, 1'b0);
      chk_bit(irq_request, 1'b1);
      wr(A_IE, 32'h0000_0005);
      @(posedge pclk);
      chk_bit(irq_request, 1'b0);
      wr(A_IE, 32'h0000_0000);
      wr(A_FL, 32'h0000_0000);
      comp_raw <= 2'b00;
      $display("test sleep done");
   endtask : t_sleep

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      comp_raw = 2'b00;
      port_direction_bit = 1'b0;
      errors = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_fields();
      t_polarity();
      t_pin();
      t_preset();
      t_flag();
      t_sleep();
      wr(A_C1, 32'h0000_00FF);
      wr(A_AX, 32'h0000_003F);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      results();
   end
endmodule : testbench
